/* File: adc_overrange_detector_tb.sv */
/*
 Self-checking bench for the overrange detector: bus, thresholds, hold, modes, calibration.
 Assumes a zero-wait slave; every wait is still bounded.
*/
`timescale 1ns/10ps
module adc_overrange_detector_tb;
    import ovr_pkg::*;
    logic         ref_clk = 1'b0;
    logic         rst = 1'b1;
    sample_pair_t in_a = '0;
    sample_pair_t in_b = '0;
    logic         sample_valid = 1'b0;
    logic         hsel = 1'b0;
    logic [31:0]  haddr = '0;
    logic [1:0]   htrans = 2'h0;
    logic         hwrite = 1'b0;
    logic [31:0]  hwdata = '0;
    logic         single_mode = 1'b0;
    logic [31:0]  rd;
    wire  [31:0]  hrdata;
    wire          hreadyout, hresp, samp_on, upper_seen, lower_seen;
    wire ovr_flags_t flags;
    int           mismatches = 0;
    int           cmp_count = 0;
    initial forever #10 ref_clk = ~ref_clk;
    ovr_detect ovr_detect_inst (.ref_clk(ref_clk), .rst(rst), .input_a_positive(in_a),
        .input_b_positive(in_b), .sample_valid(sample_valid), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .chan_a_upper_flag(flags.a_upper), .chan_a_lower_flag(flags.a_lower),
        .chan_b_upper_flag(flags.b_upper), .chan_b_lower_flag(flags.b_lower),
        .sampling_active(samp_on));
    gain_monitor_model gain_monitor_model_inst (.single_mode(single_mode), .flags(flags),
        .upper_seen(upper_seen), .lower_seen(lower_seen));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("Counts: %0d mismatches, %0d comparisons", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Step whole cycles, then look once the edge has settled
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic wait_rdy;
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            if (hreadyout === 1'b1) return;
        end
        mismatches++;
        summarize();
    endtask : wait_rdy
    // One single transfer: address phase, then data phase, each held until ready
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    // One sample cycle, {a.rise, a.fall, b.rise, b.fall}; flags checked after it
    task automatic hit(input logic [31:0] s);
        @(posedge ref_clk);
        {in_a, in_b} <= s;
        sample_valid <= 1'b1;
        @(posedge ref_clk);
        {in_a, in_b} <= 32'h0;
        sample_valid <= 1'b0;
        #1;
    endtask : hit
    task automatic t_regs;
        bus(1'b0, ADDR_ID, 32'h0); chk(rd, ID_VALUE);
        bus(1'b0, ADDR_THRESH, 32'h0); chk(rd, 32'h00004072);
        bus(1'b0, ADDR_CTRL, 32'h0); chk(rd, 32'h0);
        bus(1'b0, 32'h00000010, 32'h0); chk(rd, 32'h0);
        bus(1'b1, ADDR_THRESH, 32'h00002064);
        bus(1'b0, ADDR_THRESH, 32'h0); chk(rd, 32'h00002064);
    endtask : t_regs
    // Upper 100, lower 32: magnitudes just below and at each threshold
    task automatic t_thresh;
        hit(32'h9D7F9C00); chk({28'h0, flags}, 32'h7);
        chk({30'h0, upper_seen, lower_seen}, 32'h1);
        tick(7); chk({28'h0, flags}, 32'h7);
        tick(1); chk({28'h0, flags}, 32'h0);
        hit(32'hE1002000); chk({28'h0, flags}, 32'h1);
        tick(3);
        hit(32'hE1002000);
        tick(7); chk({28'h0, flags}, 32'h1);
        tick(1); chk({28'h0, flags}, 32'h0);
    endtask : t_thresh
    task automatic t_hold;
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, ADDR_CTRL, 32'(s) << CTRL_HOLD_LSB);
            hit(32'h80000000);
            tick((8 << s) - 1); chk({28'h0, flags}, 32'hC);
            tick(1); chk({28'h0, flags}, 32'h0);
        end
    endtask : t_hold
    task automatic t_single;
        bus(1'b1, ADDR_CTRL, 32'h1);
        single_mode <= 1'b1;
        hit(32'h00000081); chk({28'h0, flags}, 32'h3);
        chk({30'h0, upper_seen, lower_seen}, 32'h3);
        tick(10);
    endtask : t_single
    task automatic t_cal;
        bus(1'b1, ADDR_CTRL, 32'h4);
        single_mode <= 1'b0;
        tick(2); chk({31'h0, samp_on}, 32'h0);
        hit(32'h7F7F7F7F); chk({28'h0, flags}, 32'h0);
        bus(1'b0, ADDR_STATUS, 32'h0); chk(rd, 32'h20);
        for (int i = 0; i < 150 && samp_on !== 1'b1; i++) tick(1);
        chk({31'h0, samp_on}, 32'h1);
        bus(1'b1, ADDR_CTRL, 32'h6);
        tick(2); chk({31'h0, samp_on}, 32'h1);
        hit(32'h7F007F00); chk({28'h0, flags}, 32'hF);
    endtask : t_cal
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_thresh();
        t_hold();
        t_single();
        t_cal();
        summarize();
    end
endmodule : adc_overrange_detector_tb
bind ovr_detect ovr_detect_monitor ovr_detect_monitor_inst (.ref_clk(ref_clk), .rst(rst),
    .input_a_positive(input_a_positive), .input_b_positive(input_b_positive),
    .sample_valid(sample_valid), .hreadyout(hreadyout), .hresp(hresp),
    .chan_a_upper_flag(chan_a_upper_flag), .chan_a_lower_flag(chan_a_lower_flag),
    .chan_b_upper_flag(chan_b_upper_flag), .chan_b_lower_flag(chan_b_lower_flag),
    .sampling_active(sampling_active));

/* File: gain_monitor_model.sv */
/*
 Downstream gain-control view of the four overrange flags.
 Assumes the flags are synchronous levels; in dual mode only channel A is watched.
*/
`timescale 1ns/10ps
module gain_monitor_model (
    input  wire logic                single_mode,
    input  wire ovr_pkg::ovr_flags_t flags,
    output logic                     upper_seen,
    output logic                     lower_seen
);
    import ovr_pkg::*;
    // Single mode splits one stream over both channels, so either side counts
    assign upper_seen = flags.a_upper | (single_mode & flags.b_upper);
    assign lower_seen = flags.a_lower | (single_mode & flags.b_lower);
endmodule : gain_monitor_model

/* File: ovr_detect.sv */
/*
 Overrange detector with AHB-Lite register slave and calibration mode control.
 Assumes samples arrive synchronous to ref_clk, two per clock for each channel.
*/
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
module ovr_detect (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire ovr_pkg::sample_pair_t input_a_positive,
    input  wire ovr_pkg::sample_pair_t input_b_positive,
    input  wire logic                  sample_valid,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic                       chan_a_upper_flag,
    output logic                       chan_a_lower_flag,
    output logic                       chan_b_upper_flag,
    output logic                       chan_b_lower_flag,
    output logic                       sampling_active
);
    import ovr_pkg::*;

    // Signed code to magnitude; most negative code saturates
    // Negating -128 in eight bits wraps back to -128, hence the explicit case
    function automatic logic [MAG_W-1:0] magnitude(input logic [SAMPLE_W-1:0] code);
        logic [SAMPLE_W-1:0] neg;
        neg = -code;
        if (code == {1'b1, {(SAMPLE_W-1){1'b0}}}) magnitude = '1; // [RL3]
        else if (code[SAMPLE_W-1]) magnitude = neg[MAG_W-1:0];     // [RL2]
        else magnitude = code[MAG_W-1:0];
    endfunction : magnitude

    // Threshold test shared by all four compare paths
    function automatic logic reaches(input logic [SAMPLE_W-1:0] code,
                                     input logic [MAG_W-1:0]    thr);
        reaches = magnitude(code) >= thr;                          // [RL5]
    endfunction : reaches

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [MAG_W-1:0] upper_overrange_threshold;
    logic [MAG_W-1:0] lower_overrange_threshold;
    logic [2:0]       overrange_hold_select;
    logic             single_mode;
    logic             bg_cal;
    logic             ap_write;
    logic [7:0]       ap_addr;
    logic [MAG_W-1:0] next_upper;
    logic [MAG_W-1:0] next_lower;
    logic [2:0]       next_hold;
    logic             next_single;
    logic             next_bg;
    logic             next_ap_write;
    logic [7:0]       next_ap_addr;
    logic [31:0]      next_hrdata;
    logic             cal_go;
    logic             ap_take;
    ovr_flags_t       flags;
    // Only the foreground calibration state is read back, as one bit of the status word
    cal_state_t       cal_state;
    cal_state_t       next_cal_state;

    // Only NONSEQ starts a transfer; IDLE and BUSY are ignored, hsize is not checked
    assign ap_take = hsel && hready && (htrans == HTRANS_NONSEQ);

    // Zero-wait slave: address phase latched, write applied in data phase
    always_comb begin
        next_upper    = upper_overrange_threshold;
        next_lower    = lower_overrange_threshold;
        next_hold     = overrange_hold_select;
        next_single   = single_mode;
        next_bg       = bg_cal;
        cal_go        = 1'b0;
        next_ap_write = ap_take && hwrite;
        next_ap_addr  = ap_take ? haddr[7:0] : ap_addr;
        next_hrdata   = hrdata;
        // Writes land at the end of the data phase
        // The start bit is a one-cycle pulse and never reads back
        if (ap_write) begin
            case (ap_addr)
                ADDR_CTRL: begin
                    next_single = hwdata[CTRL_SINGLE];
                    next_bg     = hwdata[CTRL_BGCAL];
                    cal_go      = hwdata[CTRL_CALGO];
                    next_hold   = hwdata[CTRL_HOLD_LSB +: 3];          // [RL8]
                end
                ADDR_THRESH: begin
                    next_upper = hwdata[MAG_W-1:0];                    // [RL4]
                    next_lower = hwdata[THR_LOWER_LSB +: MAG_W];       // [RL4]
                end
                default: ;
            endcase
        end
        // Read data loads at the address edge and stands through the data phase
        if (ap_take && !hwrite) begin
            case (haddr[7:0])
                ADDR_CTRL:   next_hrdata = {25'h0, overrange_hold_select, 2'h0,
                                            bg_cal, single_mode};
                ADDR_THRESH: next_hrdata = {17'h0, lower_overrange_threshold,
                                            1'b0, upper_overrange_threshold};
                ADDR_STATUS: next_hrdata = {26'h0, cal_state == CAL_FG, sampling_active,
                                            flags};
                ADDR_ID:     next_hrdata = ID_VALUE;
                default:     next_hrdata = 32'h0;
            endcase
        end
    end

    // Register bank; reset gives dual mode, foreground calibration and default thresholds
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            upper_overrange_threshold <= UPPER_RESET;
            lower_overrange_threshold <= LOWER_RESET;
            overrange_hold_select     <= HOLD_RESET;
            single_mode               <= 1'b0;
            bg_cal                    <= 1'b0;
            ap_write                  <= 1'b0;
            ap_addr                   <= 8'h00;
            hrdata                    <= 32'h0;
        end else begin
            upper_overrange_threshold <= next_upper;
            lower_overrange_threshold <= next_lower;
            overrange_hold_select     <= next_hold;
            single_mode               <= next_single;
            bg_cal                    <= next_bg;
            ap_write                  <= next_ap_write;
            ap_addr                   <= next_ap_addr;
            hrdata                    <= next_hrdata;
        end
    end

    // Every access completes at once with OKAY; no wait states are ever inserted
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Calibration sequencer
    logic [7:0] cal_count;
    logic [7:0] next_cal_count;
    logic       next_active;

    // Foreground stops sampling; background keeps conversion running
    always_comb begin
        next_cal_state = cal_state;
        next_cal_count = cal_count;
        case (cal_state)
            CAL_IDLE: if (cal_go) begin
                // Mode bit written with the start bit decides, not the stale one
                next_cal_state = next_bg ? CAL_BG : CAL_FG;            // [RL9]
                next_cal_count = CAL_CYCLES;
            end
            CAL_FG, CAL_BG: begin
                if (cal_count <= 8'h01) next_cal_state = CAL_IDLE;
                next_cal_count = (cal_count == 8'h00) ? 8'h00 : cal_count - 8'h01;
            end
            default: next_cal_state = CAL_IDLE;
        endcase
        next_active = (next_cal_state != CAL_FG);                      // [RL9]
    end

    // Sampling is enabled out of reset so flags work without a calibration first
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cal_state       <= CAL_IDLE;
            cal_count       <= 8'h00;
            sampling_active <= 1'b1;
        end else begin
            cal_state       <= next_cal_state;
            cal_count       <= next_cal_count;
            sampling_active <= next_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Threshold compare; falling-edge sample only counts in single mode
    // A zero threshold trips on every valid sample, since the test is at or above
    // Limitation: thresholds are 7 bits, so a full-scale sample trips both
    logic hit_au;
    logic hit_al;
    logic hit_bu;
    logic hit_bl;
    logic take;

    assign take   = sample_valid && sampling_active;
    assign hit_au = take && (reaches(input_a_positive.rise, upper_overrange_threshold) ||
                    (single_mode && reaches(input_a_positive.fall,
                                            upper_overrange_threshold)));   // [RL1] [RL4]
    assign hit_al = take && (reaches(input_a_positive.rise, lower_overrange_threshold) ||
                    (single_mode && reaches(input_a_positive.fall,
                                            lower_overrange_threshold)));   // [RL1]
    assign hit_bu = take && (reaches(input_b_positive.rise, upper_overrange_threshold) ||
                    (single_mode && reaches(input_b_positive.fall,
                                            upper_overrange_threshold)));   // [RL1]
    assign hit_bl = take && (reaches(input_b_positive.rise, lower_overrange_threshold) ||
                    (single_mode && reaches(input_b_positive.fall,
                                            lower_overrange_threshold)));   // [RL1]

    // One hold stage per output pin, each from its own flip-flop
    // All four share one hold select, so a change applies to every pin at once
    ovr_hold u_au (.ref_clk(ref_clk), .rst(rst), .hit(hit_au),
                   .hold_sel(overrange_hold_select), .flag(flags.a_upper));   // [RL6]
    ovr_hold u_al (.ref_clk(ref_clk), .rst(rst), .hit(hit_al),
                   .hold_sel(overrange_hold_select), .flag(flags.a_lower));   // [RL6]
    ovr_hold u_bu (.ref_clk(ref_clk), .rst(rst), .hit(hit_bu),
                   .hold_sel(overrange_hold_select), .flag(flags.b_upper));   // [RL6]
    ovr_hold u_bl (.ref_clk(ref_clk), .rst(rst), .hit(hit_bl),
                   .hold_sel(overrange_hold_select), .flag(flags.b_lower));   // [RL6]

    // Pins copy the hold flip-flops with no logic in between
    assign chan_a_upper_flag = flags.a_upper;
    assign chan_a_lower_flag = flags.a_lower;
    assign chan_b_upper_flag = flags.b_upper;
    assign chan_b_lower_flag = flags.b_lower;
endmodule : ovr_detect

/* File: ovr_detect_monitor.sv */
/*
 Checker for the overrange detector ports.
 Assumes thresholds fit 7 bits, so a full-scale sample always trips both.
*/
`timescale 1ns/10ps
module ovr_detect_monitor (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire ovr_pkg::sample_pair_t input_a_positive,
    input  wire ovr_pkg::sample_pair_t input_b_positive,
    input  wire logic                  sample_valid,
    input  wire logic                  hreadyout,
    input  wire logic                  hresp,
    input  wire logic                  chan_a_upper_flag,
    input  wire logic                  chan_a_lower_flag,
    input  wire logic                  chan_b_upper_flag,
    input  wire logic                  chan_b_lower_flag,
    input  wire logic                  sampling_active
);
    import ovr_pkg::*;
    logic hit_a;
    logic hit_b;
    // Full-scale rise sample: 0x7F or 0x80, magnitude 127 either way
    assign hit_a = sample_valid && sampling_active && input_a_positive.rise[6:0] ==
                   (input_a_positive.rise[7] ? 7'h00 : 7'h7F);
    assign hit_b = sample_valid && sampling_active && input_b_positive.rise[6:0] ==
                   (input_b_positive.rise[7] ? 7'h00 : 7'h7F);
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_max_a_up; hit_a |=> chan_a_upper_flag[*8]; endproperty
    property p_max_a_lo; hit_a |=> chan_a_lower_flag[*8]; endproperty
    property p_max_b_up; hit_b |=> chan_b_upper_flag[*8]; endproperty
    // Hold is at least 8 cycles, so a drop needs a quiet stretch behind it
    property p_fall_a; $fell(chan_a_upper_flag) |-> !$past(hit_a, 1) && !$past(hit_a, 8);
    endproperty
    property p_fall_b; $fell(chan_b_upper_flag) |-> !$past(hit_b, 1) && !$past(hit_b, 4);
    endproperty
    property p_cal_quiet; !sampling_active && !chan_a_upper_flag |=> !chan_a_upper_flag;
    endproperty
    property p_cause; $rose(chan_b_lower_flag) |-> $past(sample_valid && sampling_active);
    endproperty
    property p_okay; hreadyout && !hresp; endproperty
    a_max_a_up: assert property (p_max_a_up) else $error("a upper flag not held");
    a_max_a_lo: assert property (p_max_a_lo) else $error("a lower flag not held");
    a_max_b_up: assert property (p_max_b_up) else $error("b upper flag not held");
    a_fall_a: assert property (p_fall_a) else $error("a upper dropped early");
    a_fall_b: assert property (p_fall_b) else $error("b upper dropped early");
    a_cal_quiet: assert property (p_cal_quiet) else $error("flag set in calibration");
    a_cause: assert property (p_cause) else $error("b lower rose without sample");
    a_okay: assert property (p_okay) else $error("bus not ready or not okay");
    cover property (hit_a);
    cover property ($fell(chan_a_upper_flag));
    cover property (!sampling_active);
endmodule : ovr_detect_monitor

/* File: ovr_hold.sv */
/*
 One overrange flag with restartable hold counter.
 Assumes hit is a synchronous one-cycle qualifier.
*/
`timescale 1ns/10ps
module ovr_hold (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                hit,
    input  wire logic [2:0]          hold_sel,
    output logic                     flag
);
    import ovr_pkg::*;

    logic [HOLD_W-1:0] count;
    logic [HOLD_W-1:0] next_count;
    logic              next_flag;

    // Hit reloads the full length so the flag drops only after a quiet period
    always_comb begin
        next_count = count;
        next_flag  = flag;
        if (hit) begin
            next_count = HOLD_W'(HOLD_BASE << hold_sel); // [RL8] [RL12]
            next_flag  = 1'b1;                           // [RL5]
        end else if (count > HOLD_W'(1)) begin
            next_count = count - HOLD_W'(1);
        end else begin
            next_count = '0;
            next_flag  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            flag  <= 1'b0;
        end else begin
            count <= next_count;
            flag  <= next_flag;
        end
    end
endmodule : ovr_hold

/* File: ovr_pkg.sv */
/*
 Shared constants and carrier types for the overrange detector.
 Assumes a single 50 MHz clock and AHB-Lite register access.
*/
// Functional notes
// RL1: dual mode samples on rising edge; single mode delivers both edge samples per clock.
// RL2: samples are signed two's complement; positive when non-inverting input is higher.
// RL3: magnitude is 7 bits; -128 saturates to 127.
// RL4: two programmable thresholds, shared by channels A and B.
// RL5: flag is 1 when magnitude is at or above threshold, else 0.
// RL6: each channel drives an upper and a lower flag output.
// RL7: in single mode the monitor ORs A and B flags per threshold.
// RL8: 3-bit hold select gives 8 to 1024 clock hold length.
// RL9: calibration runs in foreground (sampling stops) or background (continuous).
// RL10: controller recalibrates after large temperature changes.
// RL11: suggested upper threshold near full scale, lower threshold around 64.
// RL12: each qualifying sample restarts hold; flag drops after quiet hold period.
package ovr_pkg;
    localparam int          SAMPLE_W      = 8;
    localparam int          MAG_W         = 7;
    localparam int          HOLD_W        = 11;
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_THRESH   = 8'h04;
    localparam logic [7:0]  ADDR_STATUS   = 8'h08;
    localparam logic [7:0]  ADDR_ID       = 8'h0C;
    localparam logic [31:0] ID_VALUE      = 32'h0000A5A5; // Arbitrary value
    localparam logic [6:0]  UPPER_RESET   = 7'h72;
    localparam logic [6:0]  LOWER_RESET   = 7'h40;
    localparam logic [2:0]  HOLD_RESET    = 3'h0;
    localparam logic [10:0] HOLD_BASE     = 11'h008;
    localparam int          CTRL_SINGLE   = 0;
    localparam int          CTRL_BGCAL    = 1;
    localparam int          CTRL_CALGO    = 2;
    localparam int          CTRL_HOLD_LSB = 4;
    localparam int          THR_LOWER_LSB = 8;
    localparam int          CAL_TIME_NS   = 2000;
    localparam int          CLK_NS        = 20;
    localparam logic [7:0]  CAL_CYCLES    = 8'((CAL_TIME_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [SAMPLE_W-1:0] rise;
        logic [SAMPLE_W-1:0] fall;
    } sample_pair_t;

    typedef struct packed {
        logic a_upper;
        logic a_lower;
        logic b_upper;
        logic b_lower;
    } ovr_flags_t;

    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_FG,
        CAL_BG
    } cal_state_t;
endpackage : ovr_pkg
